// file: rtl/measurement_status_event_model.sv
/*
 Status event model: four event sets with latch, mask and summary,
 measurement and questionable condition logic, message-available flag.
 Assumes a host command port synchronous to clock, one command per cycle.
*/
// Operation
// - Events latch to one until read, clear-status or reset
// - Reading event register returns then clears it
// - Power-up, clear-status zero events; preset doesn't
// - Event bits ANDed with set's enable mask
// - Any enabled event drives set summary high
// - Power-up, preset zero masks; clear-status doesn't
// - Standard mask eight bits, others sixteen
// - Condition registers mirror live state, no latching
// - B0 over range, B1-B4 limit hits
// - B5 sets per processed reading
// - B6 sets when count reaches notify
// - B7 means two or more stored
// - Quarter B12, half B8, three-quarter B13, full B9
// - B10 sets when full store wraps
// - B11 hardware limit; B14 any limit
// - Questionable B4 invalid reference junction
// - Questionable B8 bad cal until recalibrated
// - Questionable B14 ignored command parameter
// - Error lamp follows questionable events present
// - Message flag follows non-empty output queue
`include "status_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module status_event_set #(
   parameter int W = 16
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [W-1:0] cond,
   input  wire logic         rd_clr,
   input  wire logic         cls,
   input  wire logic         preset,
   input  wire logic         wr_mask,
   input  wire logic [W-1:0] wdata,
   output logic      [W-1:0] event_r,
   output logic      [W-1:0] mask_r,
   output logic              summary
);
   logic [W-1:0] prev_r;
   logic [W-1:0] rise;

   assign rise = cond & ~prev_r;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prev_r <= '0;
      end else begin
         prev_r <= cond;
      end
   end

   // Set wins over read-clear and clear-status
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         event_r <= '0;
      end else if (rd_clr || cls) begin
         event_r <= rise;
      end else begin
         event_r <= event_r | rise;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mask_r <= '0;
      end else if (preset) begin
         mask_r <= '0;
      end else if (wr_mask) begin
         mask_r <= wdata;
      end
   end

   assign summary = |(event_r & mask_r);

   a_latch_hold: assert property (@(posedge clock) disable iff (rst)
      !rd_clr && !cls |=> (event_r & $past(event_r)) == $past(event_r))
      else $error("event bit dropped without clear");
   a_read_clear: assert property (@(posedge clock) disable iff (rst)
      rd_clr |=> event_r == $past(rise))
      else $error("event register not cleared by read");
   a_cls_zero: assert property (@(posedge clock) disable iff (rst)
      cls |=> event_r == $past(rise))
      else $error("clear-status left event bits");
   a_preset_keeps: assert property (@(posedge clock) disable iff (rst)
      preset && !cls && !rd_clr |=> event_r == ($past(event_r) | $past(rise)))
      else $error("preset changed event bits");
   a_preset_mask: assert property (@(posedge clock) disable iff (rst)
      preset |=> mask_r == '0)
      else $error("preset did not clear mask");
   a_cls_mask: assert property (@(posedge clock) disable iff (rst)
      cls && !wr_mask |=> mask_r == $past(mask_r))
      else $error("clear-status changed mask");
   a_mask_write: assert property (@(posedge clock) disable iff (rst)
      wr_mask && !preset |=> mask_r == $past(wdata))
      else $error("mask write lost");
   a_summary_rise: assert property (@(posedge clock) disable iff (rst)
      !rd_clr && !cls && !preset && !wr_mask && summary |=> summary)
      else $error("summary fell without clear");
endmodule : status_event_set

////////////////////////////////////////////////////////////////////////////////
module measurement_status_event_model #(
   parameter int CW = `STORE_CW,
   parameter int MW = `MSG_CW
) (
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire status_pkg::cmd_op_e     cmd_op,
   input  wire status_pkg::set_sel_e    cmd_sel,
   input  wire logic                    cmd_valid,
   input  wire logic [`SET_W-1:0]       cmd_data,
   output logic                         resp_valid,
   output logic      [`SET_W-1:0]       resp_data,
   input  wire logic                    reading_over_range,
   input  wire logic                    lower_bound_one_hit,
   input  wire logic                    upper_bound_one_hit,
   input  wire logic                    lower_bound_two_hit,
   input  wire logic                    upper_bound_two_hit,
   input  wire logic                    hardware_bound_hit,
   input  wire logic                    new_reading_ready,
   input  wire logic                    store_wrapped,
   input  wire logic [CW-1:0]           store_count,
   input  wire logic [CW-1:0]           store_size,
   input  wire logic [CW-1:0]           store_notify_count,
   input  wire logic                    junction_invalid,
   input  wire logic                    cal_constant_bad,
   input  wire logic                    cal_done_ok,
   input  wire logic                    command_param_ignored,
   input  wire logic [`SET_W-1:0]       operation_condition,
   input  wire logic [`STD_W-1:0]       standard_event_pulse,
   input  wire logic                    msg_push,
   input  wire logic                    msg_pop,
   output logic                         standard_summary,
   output logic                         operation_summary,
   output logic                         measure_summary,
   output logic                         questionable_summary,
   output logic                         message_waiting,
   output logic                         error_lamp
);
   logic [`SET_W-1:0] measure_condition_live;
   logic [`SET_W-1:0] questionable_condition_live;
   logic [`SET_W-1:0] measure_event_latch;
   logic [`SET_W-1:0] measure_event_mask;
   logic [`SET_W-1:0] questionable_event_latch;
   logic [`SET_W-1:0] questionable_event_mask;
   logic [`SET_W-1:0] operation_event_latch;
   logic [`SET_W-1:0] operation_event_mask;
   logic [`STD_W-1:0] standard_event_latch;
   logic [`STD_W-1:0] standard_event_mask;
   logic              cal_bad_r;
   logic [MW-1:0]     msg_count_r;
   logic [CW+1:0]     cnt_x4;
   logic [CW+1:0]     size_x3;
   logic              rd_evt;
   logic              cls;
   logic              preset;
   logic              wr_mask;
   logic [3:0]        rd_clr;
   logic [3:0]        wr_sel;

   ////////////////////////////////////////////////////////////////////////////
   // Command decode
   assign rd_evt  = cmd_valid && (cmd_op == status_pkg::op_read_event);
   assign cls     = cmd_valid && (cmd_op == status_pkg::op_clear_status);
   assign preset  = cmd_valid && (cmd_op == status_pkg::op_preset);
   assign wr_mask = cmd_valid && (cmd_op == status_pkg::op_write_mask);

   always_comb begin
      rd_clr = 4'h0;
      wr_sel = 4'h0;
      rd_clr[cmd_sel] = rd_evt;
      wr_sel[cmd_sel] = wr_mask;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Measurement condition, live
   assign cnt_x4  = {store_count, 2'b00};
   assign size_x3 = {2'b00, store_size} + {1'b0, store_size, 1'b0};

   always_comb begin
      measure_condition_live = 16'h0000;
      measure_condition_live[`MB_OVER_RANGE] = reading_over_range;
      measure_condition_live[`MB_LOW_ONE]    = lower_bound_one_hit;
      measure_condition_live[`MB_HIGH_ONE]   = upper_bound_one_hit;
      measure_condition_live[`MB_LOW_TWO]    = lower_bound_two_hit;
      measure_condition_live[`MB_HIGH_TWO]   = upper_bound_two_hit;
      measure_condition_live[`MB_READING]    = new_reading_ready;
      measure_condition_live[`MB_COUNT_REACHED] =
         (store_notify_count != '0) && (store_count >= store_notify_count);
      measure_condition_live[`MB_HAS_READINGS] =
         store_count >= CW'(2);
      measure_condition_live[`MB_QUARTER] = (store_size != '0) &&
         (cnt_x4 >= {2'b00, store_size});
      measure_condition_live[`MB_HALF] = (store_size != '0) &&
         ({1'b0, store_count, 1'b0} >= {2'b00, store_size});
      measure_condition_live[`MB_THREE_QUARTER] = (store_size != '0) &&
         (cnt_x4 >= size_x3);
      measure_condition_live[`MB_FULL] = (store_size != '0) &&
         (store_count >= store_size);
      measure_condition_live[`MB_WRAPPED] = store_wrapped;
      measure_condition_live[`MB_HW_BOUND] = hardware_bound_hit;
      measure_condition_live[`MB_ANY_BOUND] = lower_bound_one_hit |
         upper_bound_one_hit | lower_bound_two_hit |
         upper_bound_two_hit | hardware_bound_hit;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Calibration flag: set by bad constant, held until good calibration
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cal_bad_r <= 1'b0;
      end else if (cal_constant_bad) begin
         cal_bad_r <= 1'b1;
      end else if (cal_done_ok) begin
         cal_bad_r <= 1'b0;
      end
   end

   always_comb begin
      questionable_condition_live = 16'h0000;
      questionable_condition_live[`QB_TEMP] = junction_invalid;
      questionable_condition_live[`QB_CAL]  = cal_bad_r;
      questionable_condition_live[`QB_WARN] = command_param_ignored;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event sets
   status_event_set #(.W(`STD_W)) u_standard (
      .clock   (clock),
      .rst     (rst),
      .cond    (standard_event_pulse),
      .rd_clr  (rd_clr[status_pkg::sel_standard]),
      .cls     (cls),
      .preset  (preset),
      .wr_mask (wr_sel[status_pkg::sel_standard]),
      .wdata   (cmd_data[`STD_W-1:0]),
      .event_r (standard_event_latch),
      .mask_r  (standard_event_mask),
      .summary (standard_summary)
   );

   status_event_set #(.W(`SET_W)) u_operation (
      .clock   (clock),
      .rst     (rst),
      .cond    (operation_condition),
      .rd_clr  (rd_clr[status_pkg::sel_operation]),
      .cls     (cls),
      .preset  (preset),
      .wr_mask (wr_sel[status_pkg::sel_operation]),
      .wdata   (cmd_data),
      .event_r (operation_event_latch),
      .mask_r  (operation_event_mask),
      .summary (operation_summary)
   );

   status_event_set #(.W(`SET_W)) u_measure (
      .clock   (clock),
      .rst     (rst),
      .cond    (measure_condition_live),
      .rd_clr  (rd_clr[status_pkg::sel_measure]),
      .cls     (cls),
      .preset  (preset),
      .wr_mask (wr_sel[status_pkg::sel_measure]),
      .wdata   (cmd_data),
      .event_r (measure_event_latch),
      .mask_r  (measure_event_mask),
      .summary (measure_summary)
   );

   status_event_set #(.W(`SET_W)) u_questionable (
      .clock   (clock),
      .rst     (rst),
      .cond    (questionable_condition_live),
      .rd_clr  (rd_clr[status_pkg::sel_questionable]),
      .cls     (cls),
      .preset  (preset),
      .wr_mask (wr_sel[status_pkg::sel_questionable]),
      .wdata   (cmd_data),
      .event_r (questionable_event_latch),
      .mask_r  (questionable_event_mask),
      .summary (questionable_summary)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read answers, one cycle after the command
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         resp_valid <= 1'b0;
         resp_data  <= 16'h0000;
      end else begin
         resp_valid <= cmd_valid && (cmd_op == status_pkg::op_read_event ||
                       cmd_op == status_pkg::op_read_cond ||
                       cmd_op == status_pkg::op_read_mask);
         unique case (cmd_valid ? cmd_op : status_pkg::op_write_mask)
            status_pkg::op_read_event: begin
               unique case (cmd_sel)
                  status_pkg::sel_standard:     resp_data <= {8'h00, standard_event_latch};
                  status_pkg::sel_operation:    resp_data <= operation_event_latch;
                  status_pkg::sel_measure:      resp_data <= measure_event_latch;
                  status_pkg::sel_questionable: resp_data <= questionable_event_latch;
               endcase
            end
            status_pkg::op_read_cond: begin
               unique case (cmd_sel)
                  status_pkg::sel_standard:     resp_data <= 16'h0000;
                  status_pkg::sel_operation:    resp_data <= operation_condition;
                  status_pkg::sel_measure:      resp_data <= measure_condition_live;
                  status_pkg::sel_questionable: resp_data <= questionable_condition_live;
               endcase
            end
            status_pkg::op_read_mask: begin
               unique case (cmd_sel)
                  status_pkg::sel_standard:     resp_data <= {8'h00, standard_event_mask};
                  status_pkg::sel_operation:    resp_data <= operation_event_mask;
                  status_pkg::sel_measure:      resp_data <= measure_event_mask;
                  status_pkg::sel_questionable: resp_data <= questionable_event_mask;
               endcase
            end
            default: resp_data <= resp_data;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error lamp
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         error_lamp <= 1'b0;
      end else begin
         error_lamp <= |questionable_event_latch;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output queue occupancy and message flag
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         msg_count_r <= '0;
      end else if (msg_push && !msg_pop && msg_count_r != '1) begin
         msg_count_r <= msg_count_r + MW'(1);
      end else if (msg_pop && !msg_push && msg_count_r != '0) begin
         msg_count_r <= msg_count_r - MW'(1);
      end
   end

   assign message_waiting = msg_count_r != '0;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_full_level: assert property (@(posedge clock) disable iff (rst)
      store_size != '0 && store_count == store_size
      |-> measure_condition_live[`MB_FULL] && measure_condition_live[`MB_HALF])
      else $error("full store not flagged");
   a_two_readings: assert property (@(posedge clock) disable iff (rst)
      store_count == CW'(1) |-> !measure_condition_live[`MB_HAS_READINGS])
      else $error("one reading flagged as two");
   a_any_bound: assert property (@(posedge clock) disable iff (rst)
      hardware_bound_hit && !$past(measure_condition_live[`MB_ANY_BOUND])
      |=> measure_event_latch[`MB_ANY_BOUND])
      else $error("any-bound event missing");
   a_error_lamp: assert property (@(posedge clock) disable iff (rst)
      questionable_event_latch != '0 |=> error_lamp)
      else $error("error lamp off with event present");
   a_msg_flag: assert property (@(posedge clock) disable iff (rst)
      msg_push && !msg_pop |=> message_waiting)
      else $error("message flag missing after push");
   a_cal_hold: assert property (@(posedge clock) disable iff (rst)
      cal_bad_r && !cal_done_ok |=> cal_bad_r [*1])
      else $error("cal flag cleared without calibration");
   a_read_answer: assert property (@(posedge clock) disable iff (rst)
      rd_evt && cmd_sel == status_pkg::sel_measure
      |=> resp_valid && resp_data == $past(measure_event_latch))
      else $error("event read answer wrong");

   c_meas_summary: cover property (@(posedge clock) disable iff (rst)
      $rose(measure_summary));
   c_read_clear: cover property (@(posedge clock) disable iff (rst)
      rd_evt && measure_event_latch != '0);
   c_cal_cycle: cover property (@(posedge clock) disable iff (rst)
      cal_bad_r ##[1:50] !cal_bad_r);
endmodule : measurement_status_event_model

`default_nettype wire

// file: rtl/status_cfg.svh
/*
 Bit positions, widths and reset values of the status event model.
 Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef STATUS_CFG_SVH
`define STATUS_CFG_SVH

`define SET_W            16
`define STD_W            8
`define MASK_RESET       16'h0000
`define STD_MASK_RESET   8'h00
`define STORE_CW         16
`define MSG_CW           8

`define MB_OVER_RANGE    0
`define MB_LOW_ONE       1
`define MB_HIGH_ONE      2
`define MB_LOW_TWO       3
`define MB_HIGH_TWO      4
`define MB_READING       5
`define MB_COUNT_REACHED 6
`define MB_HAS_READINGS  7
`define MB_HALF          8
`define MB_FULL          9
`define MB_WRAPPED       10
`define MB_HW_BOUND      11
`define MB_QUARTER       12
`define MB_THREE_QUARTER 13
`define MB_ANY_BOUND     14

`define QB_TEMP          4
`define QB_CAL           8
`define QB_WARN          14

`endif

// file: rtl/status_pkg.sv
/*
 Types of the status event model: host command codes and set selectors.
 Assumes the host issues one command per cycle at most.
*/
package status_pkg;
   typedef enum logic [2:0] {
      op_read_event,
      op_read_cond,
      op_read_mask,
      op_write_mask,
      op_clear_status,
      op_preset
   } cmd_op_e;

   typedef enum logic [1:0] {
      sel_standard,
      sel_operation,
      sel_measure,
      sel_questionable
   } set_sel_e;
endpackage : status_pkg

// file: dv/status_host.sv
/*
 Host model: issues one status command at a time and takes the answer.
 Assumes clock from the bench and no command before reset release.
*/
`timescale 1ns/1ps
`default_nettype none

module status_host (
   input  wire logic                  clock,
   output var  status_pkg::cmd_op_e   cmd_op,
   output var  status_pkg::set_sel_e  cmd_sel,
   output var  logic                  cmd_valid,
   output var  logic [15:0]           cmd_data,
   input  wire logic                  resp_valid,
   input  wire logic [15:0]           resp_data
);
   initial begin
      cmd_valid = 1'b0;
      cmd_op    = status_pkg::op_read_event;
      cmd_sel   = status_pkg::sel_standard;
      cmd_data  = 16'h0000;
   end

   // Held from just after one edge to the taking edge; values stay in range
   task automatic issue(input status_pkg::cmd_op_e op, input status_pkg::set_sel_e s,
                        input logic [15:0] d, output logic [15:0] r, output logic v);
      @(posedge clock);
      #1;
      cmd_op    = op;
      cmd_sel   = s;
      cmd_data  = d;
      cmd_valid = 1'b1;
      @(posedge clock);
      #1;
      v         = resp_valid;
      r         = resp_data;
      cmd_valid = 1'b0;
      cmd_data  = ~d;
   endtask : issue
endmodule : status_host

`default_nettype wire

// file: dv/tb.sv
/*
 Self-checking bench of the status event model, one task per scenario.
 Assumes the host model drives the command port.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic        clock, rst, reading_over_range, lower_bound_one_hit, upper_bound_one_hit;
   logic        lower_bound_two_hit, upper_bound_two_hit, hardware_bound_hit;
   logic        new_reading_ready, store_wrapped, junction_invalid, cal_constant_bad;
   logic        cal_done_ok, command_param_ignored, msg_push, msg_pop, resp_valid;
   logic        cmd_valid, standard_summary, operation_summary, measure_summary;
   logic        questionable_summary, message_waiting, error_lamp;
   logic [15:0] store_count, store_size, store_notify_count, operation_condition;
   logic [15:0] resp_data, cmd_data;
   logic [7:0]  standard_event_pulse;
   int          failures, samples_checked;
   status_pkg::cmd_op_e  cmd_op;
   status_pkg::set_sel_e cmd_sel;

   measurement_status_event_model u_dut (.clock, .rst, .cmd_op, .cmd_sel, .cmd_valid,
      .cmd_data, .resp_valid, .resp_data, .reading_over_range, .lower_bound_one_hit,
      .upper_bound_one_hit, .lower_bound_two_hit, .upper_bound_two_hit,
      .hardware_bound_hit, .new_reading_ready, .store_wrapped, .store_count, .store_size,
      .store_notify_count, .junction_invalid, .cal_constant_bad, .cal_done_ok,
      .command_param_ignored, .operation_condition, .standard_event_pulse, .msg_push,
      .msg_pop, .standard_summary, .operation_summary, .measure_summary,
      .questionable_summary, .message_waiting, .error_lamp);
   status_host u_host (.clock, .cmd_op, .cmd_sel, .cmd_valid, .cmd_data, .resp_valid,
      .resp_data);

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [15:0] got, input logic [15:0] e, input string m);
      samples_checked++;
      if (got !== e) begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, e);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step

   task automatic cmd(input status_pkg::cmd_op_e op, input status_pkg::set_sel_e s,
                      input logic [15:0] d);
      logic [15:0] r;
      logic        v;
      u_host.issue(op, s, d, r, v);
   endtask : cmd

   task automatic rd(input status_pkg::cmd_op_e op, input status_pkg::set_sel_e s,
                     input logic [15:0] e);
      logic [15:0] r;
      logic        v;
      u_host.issue(op, s, 16'h0000, r, v);
      chk(v, 16'h0001, "resp valid");
      chk(r, e, "resp data");
   endtask : rd

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      for (int i = 0; i < 4; i++) begin
         rd(status_pkg::op_read_mask, status_pkg::set_sel_e'(i), 16'h0000);
         rd(status_pkg::op_read_event, status_pkg::set_sel_e'(i), 16'h0000);
      end
      $display("t_reset done");
   endtask : t_reset

   task automatic t_latch;
      {upper_bound_two_hit, lower_bound_two_hit, upper_bound_one_hit} = 3'h7;
      {lower_bound_one_hit, reading_over_range} = 2'h3;
      step(1);
      rd(status_pkg::op_read_cond, status_pkg::sel_measure, 16'h401F);
      {upper_bound_two_hit, lower_bound_two_hit, upper_bound_one_hit} = 3'h0;
      {lower_bound_one_hit, reading_over_range} = 2'h0;
      rd(status_pkg::op_read_cond, status_pkg::sel_measure, 16'h0000);
      rd(status_pkg::op_read_event, status_pkg::sel_measure, 16'h401F);
      rd(status_pkg::op_read_event, status_pkg::sel_measure, 16'h0000);
      {new_reading_ready, store_wrapped, hardware_bound_hit} = 3'h7;
      step(1);
      {new_reading_ready, store_wrapped, hardware_bound_hit} = 3'h0;
      rd(status_pkg::op_read_event, status_pkg::sel_measure, 16'h4C20);
      $display("t_latch done");
   endtask : t_latch

   task automatic t_mask;
      new_reading_ready = 1'b1;
      step(1);
      new_reading_ready = 1'b0;
      chk(measure_summary, 16'h0000, "masked off");
      cmd(status_pkg::op_write_mask, status_pkg::sel_measure, 16'h0020);
      step(1);
      chk(measure_summary, 16'h0001, "summary on");
      cmd(status_pkg::op_write_mask, status_pkg::sel_measure, 16'h0001);
      step(1);
      chk(measure_summary, 16'h0000, "other bit");
      cmd(status_pkg::op_write_mask, status_pkg::sel_standard, 16'h01FF);
      rd(status_pkg::op_read_mask, status_pkg::sel_standard, 16'h00FF);
      cmd(status_pkg::op_write_mask, status_pkg::sel_operation, 16'hFFFF);
      rd(status_pkg::op_read_mask, status_pkg::sel_operation, 16'hFFFF);
      standard_event_pulse = 8'h80;
      operation_condition  = 16'h0400;
      step(1);
      standard_event_pulse = 8'h00;
      rd(status_pkg::op_read_cond, status_pkg::sel_operation, 16'h0400);
      chk({standard_summary, operation_summary}, 16'h0003, "sums");
      $display("t_mask done");
   endtask : t_mask

   task automatic t_clear;
      cmd(status_pkg::op_clear_status, status_pkg::sel_standard, 16'h0000);
      rd(status_pkg::op_read_event, status_pkg::sel_standard, 16'h0000);
      rd(status_pkg::op_read_event, status_pkg::sel_operation, 16'h0000);
      rd(status_pkg::op_read_mask, status_pkg::sel_operation, 16'hFFFF);
      operation_condition = 16'h0000;
      step(1);
      operation_condition = 16'h0400;
      cmd(status_pkg::op_preset, status_pkg::sel_standard, 16'h0000);
      rd(status_pkg::op_read_mask, status_pkg::sel_operation, 16'h0000);
      rd(status_pkg::op_read_mask, status_pkg::sel_measure, 16'h0000);
      rd(status_pkg::op_read_event, status_pkg::sel_operation, 16'h0400);
      $display("t_clear done");
   endtask : t_clear

   task automatic t_fill;
      logic [15:0] cnt [5] = '{16'h0001, 16'h0002, 16'h0004, 16'h0006, 16'h0008};
      logic [15:0] e [5]   = '{16'h0000, 16'h1080, 16'h1180, 16'h31C0, 16'h33C0};
      store_size         = 16'h0008;
      store_notify_count = 16'h0006;
      for (int i = 0; i < 5; i++) begin
         store_count = cnt[i];
         rd(status_pkg::op_read_cond, status_pkg::sel_measure, e[i]);
      end
      store_count = 16'h0000;
      $display("t_fill done");
   endtask : t_fill

   task automatic t_quest;
      junction_invalid = 1'b1;
      step(1);
      rd(status_pkg::op_read_cond, status_pkg::sel_questionable, 16'h0010);
      junction_invalid = 1'b0;
      chk(error_lamp, 16'h0001, "lamp on");
      cmd(status_pkg::op_write_mask, status_pkg::sel_questionable, 16'h0010);
      chk(questionable_summary, 16'h0001, "quest sum on");
      {cal_constant_bad, command_param_ignored} = 2'h3;
      step(1);
      {cal_constant_bad, command_param_ignored} = 2'h0;
      rd(status_pkg::op_read_cond, status_pkg::sel_questionable, 16'h0100);
      rd(status_pkg::op_read_event, status_pkg::sel_questionable, 16'h4110);
      chk(questionable_summary, 16'h0000, "quest sum off");
      step(1);
      chk(error_lamp, 16'h0000, "lamp off");
      cal_done_ok = 1'b1;
      step(1);
      cal_done_ok = 1'b0;
      rd(status_pkg::op_read_cond, status_pkg::sel_questionable, 16'h0000);
      $display("t_quest done");
   endtask : t_quest

   task automatic t_msg;
      msg_push = 1'b1;
      step(2);
      msg_push = 1'b0;
      chk(message_waiting, 16'h0001, "two queued");
      msg_pop = 1'b1;
      step(1);
      chk(message_waiting, 16'h0001, "one left");
      step(1);
      msg_pop = 1'b0;
      chk(message_waiting, 16'h0000, "empty");
      $display("t_msg done");
   endtask : t_msg

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {reading_over_range, lower_bound_one_hit, upper_bound_one_hit} = 3'h0;
      {lower_bound_two_hit, upper_bound_two_hit, hardware_bound_hit} = 3'h0;
      {new_reading_ready, store_wrapped, junction_invalid, cal_constant_bad} = 4'h0;
      {cal_done_ok, command_param_ignored, msg_push, msg_pop} = 4'h0;
      {store_count, store_size, store_notify_count} = 48'h0;
      operation_condition  = 16'h0000;
      standard_event_pulse = 8'h00;
      rst = 1'b1;
      step(4);
      rst = 1'b0;
      t_reset();
      t_latch();
      t_mask();
      t_clear();
      t_fill();
      t_quest();
      t_msg();
      complete_run();
   end

   initial begin
      #200000;
      failures++;
      complete_run();
   end
endmodule : tb

`default_nettype wire
